// >>> core/tpio_pkg.sv
`default_nettype none
package tpio_pkg;
   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [15:0] PORT_A_OUTPUT_LATCH = 16'h0002;
   localparam logic [15:0] PORT_B_OUTPUT_LATCH = 16'h0003;
   localparam logic [15:0] PORT_C_OUTPUT_LATCH = 16'h0004;
   localparam logic [15:0] PORT_C_PIN_LEVELS = 16'h000a;
   localparam logic [15:0] PORT_B_DIRECTION = 16'h000b;
   localparam logic [15:0] PORT_C_DIRECTION = 16'h000c;
   localparam logic [15:0] PORT_C_DRAIN_MODE = 16'h002d;
   localparam logic [15:0] PORT_A_PIN_LEVELS = 16'h0030;
   localparam logic [15:0] SYSTEM_CONTROL_ONE = 16'h0031;

   // ************************************************************
   // widths, reset values, field positions
   // ************************************************************
   localparam int A_WIDTH = 3;
   localparam int PORT_WIDTH = 8;
   localparam logic [2:0] A_LATCH_RESET = 3'h7;
   localparam logic [7:0] LATCH_RESET = 8'hff;
   localparam logic [7:0] DIR_RESET = 8'h00;
   localparam logic [7:0] DRAIN_RESET = 8'h00;
   localparam logic [4:0] A_UPPER_FILL = 5'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam int STOP_BIT = 7;
   localparam int DUAL_CLOCK_BIT = 6;
   localparam int STOP_STOP_OUTPUT_ENABLE_BIT = 4;
   localparam int STOP_RELEASE_PIN = 0;
   localparam int XTAL_IN_PIN = 1;
   localparam int XTAL_OUT_PIN = 2;
   // level on the stop-release pin that ends stop mode
   localparam logic STOP_RELEASE_LEVEL = 1'b0;

   typedef enum logic {
      MODE_RUN,
      MODE_STOP
   } tpio_mode_type;
endpackage
`default_nettype wire

// >>> core/tpio_pad.sv
`timescale 1ns/100ps
`default_nettype none
module tpio_pad (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // per-bit control
   input wire logic latch,
   input wire logic dir,
   input wire logic drain,
   input wire logic force_off,
   // pin side
   output logic pin_out,
   output logic pin_oe
);
   wire logic out_d;
   wire logic oe_d;

   // open drain only ever sinks: a latch of one releases the pin
   assign out_d = drain ? 1'b0 : latch;
   assign oe_d = !force_off && dir && (!drain || !latch);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end else begin
         pin_out <= out_d;
         pin_oe <= oe_d;
      end
   end
endmodule
`default_nettype wire

// >>> core/tpio_top.sv
`timescale 1ns/100ps
`default_nettype none
module tpio_top (
   // clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // register port
   input wire logic [15:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RD_DATA,
   // three-bit port
   input wire logic [2:0] PA_IN,
   output logic [2:0] PA_OUT,
   output logic [2:0] PA_OE,
   // first eight-bit port
   input wire logic [7:0] PB_IN,
   output logic [7:0] PB_OUT,
   output logic [7:0] PB_OE,
   // second eight-bit port
   input wire logic [7:0] PC_IN,
   output logic [7:0] PC_OUT,
   output logic [7:0] PC_OE,
   // system state
   output logic STOP_ACTIVE,
   output logic LF_OSC_ENABLE
);
   // ************************************************************
   // state
   // ************************************************************
   logic [2:0] a_latch_q;
   logic [7:0] b_latch_q;
   logic [7:0] b_dir_q;
   logic [7:0] c_latch_q;
   logic [7:0] c_dir_q;
   logic [7:0] c_drain_q;
   logic stop_output_enable_q;
   tpio_pkg::tpio_mode_type mode_q;
   tpio_pkg::tpio_mode_type mode_d;

   // ************************************************************
   // address decode
   // ************************************************************
   wire logic wr_a_latch = WR && (ADDR == tpio_pkg::PORT_A_OUTPUT_LATCH);
   wire logic wr_b_latch = WR && (ADDR == tpio_pkg::PORT_B_OUTPUT_LATCH);
   wire logic wr_c_latch = WR && (ADDR == tpio_pkg::PORT_C_OUTPUT_LATCH);
   wire logic wr_b_dir = WR && (ADDR == tpio_pkg::PORT_B_DIRECTION);
   wire logic wr_c_dir = WR && (ADDR == tpio_pkg::PORT_C_DIRECTION);
   wire logic wr_c_drain = WR && (ADDR == tpio_pkg::PORT_C_DRAIN_MODE);
   wire logic wr_sys = WR && (ADDR == tpio_pkg::SYSTEM_CONTROL_ONE);
   wire logic stop_req = wr_sys && WDATA[tpio_pkg::STOP_BIT];
   wire logic stop_clr = wr_sys && !WDATA[tpio_pkg::STOP_BIT];
   wire logic release_seen = (PA_IN[tpio_pkg::STOP_RELEASE_PIN] == tpio_pkg::STOP_RELEASE_LEVEL);

   // ************************************************************
   // read path
   // ************************************************************
   // input-direction bits show the pin, so read-modify-write copies pins into the latch
   wire logic [7:0] b_view = (b_dir_q & b_latch_q) | (~b_dir_q & PB_IN);
   wire logic [7:0] sys_view = {STOP_ACTIVE, LF_OSC_ENABLE, 1'b0, stop_output_enable_q, 4'h0};
   wire logic [7:0] rd_mux =
      (ADDR == tpio_pkg::PORT_A_OUTPUT_LATCH) ? {tpio_pkg::A_UPPER_FILL, a_latch_q} :
      (ADDR == tpio_pkg::PORT_A_PIN_LEVELS) ? {tpio_pkg::A_UPPER_FILL, PA_IN} :
      (ADDR == tpio_pkg::PORT_B_OUTPUT_LATCH) ? b_view :
      (ADDR == tpio_pkg::PORT_B_DIRECTION) ? b_dir_q :
      (ADDR == tpio_pkg::PORT_C_OUTPUT_LATCH) ? c_latch_q :
      (ADDR == tpio_pkg::PORT_C_PIN_LEVELS) ? PC_IN :
      (ADDR == tpio_pkg::PORT_C_DIRECTION) ? c_dir_q :
      (ADDR == tpio_pkg::PORT_C_DRAIN_MODE) ? c_drain_q :
      (ADDR == tpio_pkg::SYSTEM_CONTROL_ONE) ? sys_view :
      tpio_pkg::UNMAPPED_READ;

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         RD_DATA <= tpio_pkg::UNMAPPED_READ;
      end else begin
         // data stands for the one cycle after the strobe only
         RD_DATA <= RD ? rd_mux : tpio_pkg::UNMAPPED_READ;
      end
   end

   // ************************************************************
   // port registers
   // ************************************************************
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         a_latch_q <= tpio_pkg::A_LATCH_RESET;
         b_latch_q <= tpio_pkg::LATCH_RESET;
         b_dir_q <= tpio_pkg::DIR_RESET;
         c_latch_q <= tpio_pkg::LATCH_RESET;
         c_dir_q <= tpio_pkg::DIR_RESET;
         c_drain_q <= tpio_pkg::DRAIN_RESET;
      end else begin
         if (wr_a_latch) a_latch_q <= WDATA[2:0];
         if (wr_b_latch) b_latch_q <= WDATA;
         if (wr_c_latch) c_latch_q <= WDATA;
         if (wr_b_dir) b_dir_q <= WDATA;
         if (wr_c_dir) c_dir_q <= WDATA;
         if (wr_c_drain) c_drain_q <= WDATA;
      end
   end

   // ************************************************************
   // system control and stop mode
   // ************************************************************
   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         tpio_pkg::MODE_RUN: begin
            if (stop_req) mode_d = tpio_pkg::MODE_STOP;
         end
         tpio_pkg::MODE_STOP: begin
            // a fresh stop request beats a release in the same cycle
            if (!stop_req && (release_seen || stop_clr)) mode_d = tpio_pkg::MODE_RUN;
         end
         default: mode_d = tpio_pkg::MODE_RUN;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         mode_q <= tpio_pkg::MODE_RUN;
         STOP_ACTIVE <= 1'b0;
         stop_output_enable_q <= 1'b0;
         LF_OSC_ENABLE <= 1'b0;
      end else begin
         mode_q <= mode_d;
         STOP_ACTIVE <= (mode_d == tpio_pkg::MODE_STOP);
         if (wr_sys) stop_output_enable_q <= WDATA[tpio_pkg::STOP_STOP_OUTPUT_ENABLE_BIT];
         if (wr_sys) LF_OSC_ENABLE <= WDATA[tpio_pkg::DUAL_CLOCK_BIT];
      end
   end

   // ************************************************************
   // pin drivers
   // ************************************************************
   wire logic in_stop = (mode_q == tpio_pkg::MODE_STOP);
   // without the stop output enable every pin floats in stop mode
   wire logic stop_float = in_stop && !stop_output_enable_q;
   wire logic [2:0] a_force;
   // stop-release pin floats in stop mode whatever the output enable says
   assign a_force[tpio_pkg::STOP_RELEASE_PIN] = in_stop;
   // crystal pins are taken away from the port in dual-clock mode
   assign a_force[tpio_pkg::XTAL_IN_PIN] = stop_float || LF_OSC_ENABLE;
   assign a_force[tpio_pkg::XTAL_OUT_PIN] = stop_float || LF_OSC_ENABLE;

   genvar gi;
   generate
      for (gi = 0; gi < tpio_pkg::A_WIDTH; gi++) begin : g_port_a
         // sink-only pin: a latch of one leaves it free for input use
         tpio_pad u_pad (
            .clk(CLK),
            .reset_n(RESET_N),
            .latch(a_latch_q[gi]),
            .dir(1'b1),
            .drain(1'b1),
            .force_off(a_force[gi]),
            .pin_out(PA_OUT[gi]),
            .pin_oe(PA_OE[gi])
         );
      end
      for (gi = 0; gi < tpio_pkg::PORT_WIDTH; gi++) begin : g_port_bc
         tpio_pad u_pad_b (
            .clk(CLK),
            .reset_n(RESET_N),
            .latch(b_latch_q[gi]),
            .dir(b_dir_q[gi]),
            .drain(1'b0),
            .force_off(stop_float),
            .pin_out(PB_OUT[gi]),
            .pin_oe(PB_OE[gi])
         );
         tpio_pad u_pad_c (
            .clk(CLK),
            .reset_n(RESET_N),
            .latch(c_latch_q[gi]),
            .dir(c_dir_q[gi]),
            .drain(c_drain_q[gi]),
            .force_off(stop_float),
            .pin_out(PC_OUT[gi]),
            .pin_oe(PC_OE[gi])
         );
      end
   endgenerate

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);

   sequence s_wr_b;
      wr_b_latch;
   endsequence

   sequence s_b_quiet;
      !wr_b_latch;
   endsequence

   sequence s_stop_entry;
      !in_stop ##1 in_stop;
   endsequence

   reset_values_a: assert property ($rose(RESET_N) |->
      (a_latch_q == tpio_pkg::A_LATCH_RESET) && (b_latch_q == tpio_pkg::LATCH_RESET)
      && (c_latch_q == tpio_pkg::LATCH_RESET))
      else $error("latch not ones after reset");

   reset_dir_a: assert property ($rose(RESET_N) |->
      (b_dir_q == tpio_pkg::DIR_RESET) && (c_dir_q == tpio_pkg::DIR_RESET)
      && (c_drain_q == tpio_pkg::DRAIN_RESET) && (PB_OE == 8'h00) && (PC_OE == 8'h00))
      else $error("direction or drain not cleared by reset");

   a_pin_read_a: assert property ((RD && ADDR == tpio_pkg::PORT_A_PIN_LEVELS) |=>
      (RD_DATA[2:0] == $past(PA_IN)) && (RD_DATA[7:3] == tpio_pkg::A_UPPER_FILL))
      else $error("port A pin read wrong");

   a_latch_read_a: assert property ((RD && ADDR == tpio_pkg::PORT_A_OUTPUT_LATCH) |=>
      RD_DATA[2:0] == $past(a_latch_q))
      else $error("port A latch read wrong");

   stop_release_a: assert property (s_stop_entry |->
      ##1 !PA_OE[tpio_pkg::STOP_RELEASE_PIN])
      else $error("stop-release pin driven in stop");

   stop_hold_a: assert property (in_stop |=> !PA_OE[tpio_pkg::STOP_RELEASE_PIN])
      else $error("stop-release pin driven during stop");

   dual_xtal_a: assert property (LF_OSC_ENABLE |=>
      !PA_OE[tpio_pkg::XTAL_IN_PIN] && !PA_OE[tpio_pkg::XTAL_OUT_PIN])
      else $error("crystal pins driven in dual-clock mode");

   b_read_view_a: assert property ((RD && ADDR == tpio_pkg::PORT_B_OUTPUT_LATCH) |=>
      RD_DATA == (($past(b_dir_q) & $past(b_latch_q)) | (~$past(b_dir_q) & $past(PB_IN))))
      else $error("port B read view wrong");

   c_latch_read_a: assert property ((RD && ADDR == tpio_pkg::PORT_C_OUTPUT_LATCH) |=>
      RD_DATA == $past(c_latch_q))
      else $error("port C data read not latch");

   c_pin_read_a: assert property ((RD && ADDR == tpio_pkg::PORT_C_PIN_LEVELS) |=>
      RD_DATA == $past(PC_IN))
      else $error("port C pin read wrong");

   c_drain_a: assert property (1'b1 |=>
      (PC_OE & $past(c_drain_q & c_latch_q)) == 8'h00)
      else $error("open-drain bit drove high");

   c_push_a: assert property ((!stop_float && c_dir_q == 8'hff && c_drain_q == 8'h00) |=>
      (PC_OE == 8'hff) && (PC_OUT == $past(c_latch_q)))
      else $error("push-pull port C not driving latch");

   b_drive_a: assert property (s_wr_b ##1 s_b_quiet |=> PB_OUT == $past(WDATA, 2))
      else $error("port B pin not following latch write");

   b_oe_a: assert property (1'b1 |=>
      PB_OE == ($past(b_dir_q) & {8{!$past(stop_float)}}))
      else $error("port B enable not per direction");

   read_strobe_a: assert property (!RD |=> RD_DATA == tpio_pkg::UNMAPPED_READ)
      else $error("read data outside its cycle");

   sequence s_stop_req;
      stop_req;
   endsequence

   // a stop request always lands, even on top of a pending release
   stop_entry_a: assert property (s_stop_req |=>
      STOP_ACTIVE)
      else $error("stop request not entered");

   stop_float_a: assert property ((in_stop && !stop_output_enable_q) |=>
      (PB_OE == 8'h00) && (PC_OE == 8'h00) && (PA_OE == 3'h0))
      else $error("pins driven in stop without output enable");

   c_oe_a: assert property (1'b1 |=>
      PC_OE == ($past(c_dir_q) & (~$past(c_drain_q) | ~$past(c_latch_q)) & {8{!$past(stop_float)}}))
      else $error("port C enable wrong");

   c_out_a: assert property (1'b1 |=>
      PC_OUT == ($past(c_latch_q) & ~$past(c_drain_q)))
      else $error("port C output level wrong");

   a_out_a: assert property (1'b1 |=>
      PA_OUT == 3'h0)
      else $error("sink-only pin driven high");

   a_oe_run_a: assert property ((!in_stop && !LF_OSC_ENABLE) |=>
      PA_OE == ~$past(a_latch_q))
      else $error("port A enable not per latch");

   a_latch_wr_a: assert property (wr_a_latch |=>
      a_latch_q == $past(WDATA[2:0]))
      else $error("port A latch write lost");

   b_dir_wr_a: assert property (wr_b_dir |=>
      b_dir_q == $past(WDATA))
      else $error("port B direction write lost");

   c_dir_wr_a: assert property (wr_c_dir |=>
      c_dir_q == $past(WDATA))
      else $error("port C direction write lost");

   c_drain_wr_a: assert property (wr_c_drain |=>
      c_drain_q == $past(WDATA))
      else $error("port C drain mode write lost");

   c_latch_wr_a: assert property (wr_c_latch |=>
      c_latch_q == $past(WDATA))
      else $error("port C latch write lost");

   // pin levels must never leak into the latch of an input bit
   c_latch_hold_a: assert property (!wr_c_latch |=>
      $stable(c_latch_q))
      else $error("port C latch changed without write");

   b_latch_hold_a: assert property (!wr_b_latch |=>
      $stable(b_latch_q))
      else $error("port B latch changed without write");

   b_dir_read_a: assert property ((RD && ADDR == tpio_pkg::PORT_B_DIRECTION) |=>
      RD_DATA == $past(b_dir_q))
      else $error("port B direction read wrong");

   c_mode_read_a: assert property ((RD && ADDR == tpio_pkg::PORT_C_DRAIN_MODE) |=>
      RD_DATA == $past(c_drain_q))
      else $error("port C drain mode read wrong");
endmodule
`default_nettype wire

// >>> testbench/tpio_board.sv
`timescale 1ns/100ps
`default_nettype none
module tpio_board (
   // pad drivers from the device
   input wire logic [2:0] pa_out,
   input wire logic [2:0] pa_oe,
   input wire logic [7:0] pb_out,
   input wire logic [7:0] pb_oe,
   input wire logic [7:0] pc_out,
   input wire logic [7:0] pc_oe,
   // levels the board puts on released pins
   input wire logic [2:0] ext_a,
   input wire logic [7:0] ext_b,
   input wire logic [7:0] ext_c,
   // resolved pin levels
   output logic [2:0] pa_pin,
   output logic [7:0] pb_pin,
   output logic [7:0] pc_pin
);
   // ************************************************************
   // pin resolution
   // ************************************************************
   // a driving pad beats the board's weak source; released pins show the board level
   assign pa_pin = (pa_oe & pa_out) | (~pa_oe & ext_a);
   assign pb_pin = (pb_oe & pb_out) | (~pb_oe & ext_b);
   assign pc_pin = (pc_oe & pc_out) | (~pc_oe & ext_c);
endmodule
`default_nettype wire

// >>> testbench/tb_tpio_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_tpio_top;
   logic CLK, RESET_N, WR, RD, STOP_ACTIVE, LF_OSC_ENABLE;
   logic [15:0] ADDR;
   logic [7:0] WDATA, RD_DATA, PB_IN, PB_OUT, PB_OE, PC_IN, PC_OUT, PC_OE;
   logic [2:0] PA_IN, PA_OUT, PA_OE, ext_a;
   logic [7:0] ext_b, ext_c, d, lb, db, eb, lc, dc, mc, ec;
   int n_fail, check_count, cycles;

   tpio_top i_dut (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RD_DATA(RD_DATA), .PA_IN(PA_IN), .PA_OUT(PA_OUT), .PA_OE(PA_OE), .PB_IN(PB_IN),
      .PB_OUT(PB_OUT), .PB_OE(PB_OE), .PC_IN(PC_IN), .PC_OUT(PC_OUT), .PC_OE(PC_OE),
      .STOP_ACTIVE(STOP_ACTIVE), .LF_OSC_ENABLE(LF_OSC_ENABLE));
   tpio_board i_board (.pa_out(PA_OUT), .pa_oe(PA_OE), .pb_out(PB_OUT), .pb_oe(PB_OE),
      .pc_out(PC_OUT), .pc_oe(PC_OE), .ext_a(ext_a), .ext_b(ext_b), .ext_c(ext_c),
      .pa_pin(PA_IN), .pb_pin(PB_IN), .pc_pin(PC_IN));

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [7:0] c_oe(input logic [7:0] dir, drn, lat);
      return dir & (~drn | ~lat);
   endfunction

   function automatic logic [7:0] c_pin(input logic [7:0] dir, drn, lat, ext);
      return (c_oe(dir, drn, lat) & lat & ~drn) | (~c_oe(dir, drn, lat) & ext);
   endfunction

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         n_fail++;
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1;
      v = RD_DATA;
   endtask

   // pads follow the registers one edge later
   task automatic settle;
      @(posedge CLK);
      #1;
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ************************************************************
   // clock, watchdog, sequence
   // ************************************************************
   initial begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end

   always @(posedge CLK) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         end_of_test();
      end
   end

   initial begin
      RESET_N = 1'b0;
      WR = 1'b0;
      RD = 1'b0;
      ADDR = 16'h0000;
      WDATA = 8'h00;
      ext_a = 3'h5;
      ext_b = 8'h5a;
      ext_c = 8'h3c;
      n_fail = 0;
      check_count = 0;
      cycles = 0;
      void'($urandom(26));
      repeat (6) @(posedge CLK);
      RESET_N <= 1'b1;
      settle();
      chk("pa oe", 8'h00, {5'h00, PA_OE});
      chk("pb oe", 8'h00, PB_OE);
      chk("pc oe", 8'h00, PC_OE);
      chk("pb out", 8'hff, PB_OUT);
      chk("pc out", 8'hff, PC_OUT);
      rd(tpio_pkg::PORT_A_OUTPUT_LATCH, d);
      chk("a latch", 8'h07, {5'h00, d[2:0]});
      rd(tpio_pkg::PORT_B_OUTPUT_LATCH, d);
      chk("b read", 8'h5a, d);
      rd(tpio_pkg::PORT_B_DIRECTION, d);
      chk("b dir", 8'h00, d);
      rd(tpio_pkg::PORT_C_OUTPUT_LATCH, d);
      chk("c latch", 8'hff, d);
      rd(tpio_pkg::PORT_C_DIRECTION, d);
      chk("c dir", 8'h00, d);
      rd(tpio_pkg::PORT_C_DRAIN_MODE, d);
      chk("c drain", 8'h00, d);
      rd(16'h00ff, d);
      chk("unmapped", 8'h00, d);
      for (int i = 0; i < 20; i++) begin
         lb = (i == 0) ? 8'h33 : 8'($urandom);
         db = (i == 0) ? 8'h0f : 8'($urandom);
         lc = (i == 0) ? 8'hf0 : 8'($urandom);
         dc = (i < 2) ? 8'hff : 8'($urandom);
         mc = (i == 0) ? 8'haa : (i == 1) ? 8'h00 : 8'($urandom);
         eb = 8'($urandom);
         ec = 8'($urandom);
         ext_b <= eb;
         ext_c <= ec;
         wr(tpio_pkg::PORT_B_OUTPUT_LATCH, lb);
         wr(tpio_pkg::PORT_B_DIRECTION, db);
         wr(tpio_pkg::PORT_C_OUTPUT_LATCH, lc);
         wr(tpio_pkg::PORT_C_DIRECTION, dc);
         wr(tpio_pkg::PORT_C_DRAIN_MODE, mc);
         wr(tpio_pkg::PORT_C_PIN_LEVELS, ~lc);
         settle();
         chk("pb out", lb, PB_OUT);
         chk("pb oe", db, PB_OE);
         chk("pc out", lc & ~mc, PC_OUT);
         chk("pc oe", c_oe(dc, mc, lc), PC_OE);
         rd(tpio_pkg::PORT_B_OUTPUT_LATCH, d);
         chk("b read", (lb & db) | (eb & ~db), d);
         rd(tpio_pkg::PORT_C_OUTPUT_LATCH, d);
         chk("c latch", lc, d);
         rd(tpio_pkg::PORT_C_PIN_LEVELS, d);
         chk("c pins", c_pin(dc, mc, lc, ec), d);
      end
      // alternate-function setup: latches high first, then per-pin directions
      wr(tpio_pkg::PORT_B_OUTPUT_LATCH, 8'hff);
      wr(tpio_pkg::PORT_B_DIRECTION, 8'ha9);
      wr(tpio_pkg::PORT_C_OUTPUT_LATCH, 8'hff);
      wr(tpio_pkg::PORT_C_DRAIN_MODE, 8'h00);
      wr(tpio_pkg::PORT_C_DIRECTION, 8'h25);
      settle();
      chk("pb oe alt", 8'ha9, PB_OE);
      chk("pc oe alt", 8'h25, PC_OE);
      rd(tpio_pkg::PORT_B_OUTPUT_LATCH, d);
      chk("b read alt", 8'ha9 | (ext_b & 8'h56), d);
      wr(tpio_pkg::PORT_A_OUTPUT_LATCH, 8'h00);
      settle();
      chk("pa oe", 8'h07, {5'h00, PA_OE});
      chk("pa out", 8'h00, {5'h00, PA_OUT});
      rd(tpio_pkg::PORT_A_PIN_LEVELS, d);
      chk("a pins", 8'h00, {5'h00, d[2:0]});
      wr(tpio_pkg::SYSTEM_CONTROL_ONE, 8'h40);
      settle();
      chk("pa oe dual", 8'h01, {5'h00, PA_OE});
      chk("lf osc", 8'h01, {7'h00, LF_OSC_ENABLE});
      rd(tpio_pkg::SYSTEM_CONTROL_ONE, d);
      chk("sys dual", 8'h40, d);
      wr(tpio_pkg::PORT_A_OUTPUT_LATCH, 8'h07);
      wr(tpio_pkg::SYSTEM_CONTROL_ONE, 8'h00);
      rd(tpio_pkg::PORT_A_PIN_LEVELS, d);
      chk("a pins", 8'h05, {5'h00, d[2:0]});
      ext_a <= 3'h7;
      wr(tpio_pkg::PORT_A_OUTPUT_LATCH, 8'h01);
      wr(tpio_pkg::PORT_B_DIRECTION, 8'hff);
      wr(tpio_pkg::SYSTEM_CONTROL_ONE, 8'h90);
      settle();
      chk("stop", 8'h01, {7'h00, STOP_ACTIVE});
      chk("pa oe stop", 8'h06, {5'h00, PA_OE});
      chk("pb oe stop", 8'hff, PB_OE);
      rd(tpio_pkg::SYSTEM_CONTROL_ONE, d);
      chk("sys stop", 8'h90, d);
      // pulling the stop-release pin low ends stop
      ext_a <= 3'h6;
      repeat (3) @(posedge CLK);
      #1;
      chk("stop release", 8'h00, {7'h00, STOP_ACTIVE});
      ext_a <= 3'h7;
      wr(tpio_pkg::SYSTEM_CONTROL_ONE, 8'h80);
      settle();
      chk("pb oe float", 8'h00, PB_OE);
      chk("pa oe float", 8'h00, {5'h00, PA_OE});
      chk("pc oe float", 8'h00, PC_OE);
      wr(tpio_pkg::SYSTEM_CONTROL_ONE, 8'h00);
      settle();
      chk("pb oe run", 8'hff, PB_OE);
      end_of_test();
   end
endmodule
`default_nettype wire
